// ---- cpt_timer.sv ----
// Sixteen-bit compare/PWM timer with APB register slave
//
// Implementation choices: the register addresses and the APB register port.
`include "cpt_map.svh"
module cpt_timer
  import cpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fast_clk_in,
  input  wire logic              slow_clk_in,
  input  wire logic              external_timer_clock_pin,
  output logic                   compare_a_flag,
  output logic                   compare_p_flag,
  output logic                   timer_out,
  output logic                   timer_out_en
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] compare_a_value_reg;
  logic [7:0]  compare_p_value_reg;
  logic        flag_a_reg;
  logic        flag_p_reg;
  logic [31:0] prdata_reg;
  logic        on_last_reg;
  logic        cmp_out_reg;
  logic        cmp_out_next;
  logic        pin_reg;
  logic        pin_en_reg;

  // ==========================================================================
  // Control field decode
  // ==========================================================================
  // Named views of the control bits
  wire         counter_pause         = ctrl0_reg[`CPT_PAUSE_BIT];
  wire         counter_on            = ctrl0_reg[`CPT_ON_BIT];
  wire [2:0]   clock_source_select   = ctrl0_reg[`CPT_CLKSRC_HI:`CPT_CLKSRC_LO];
  wire         op_mode_hi            = ctrl1_reg[`CPT_MODE_HI];
  wire         op_mode_lo            = ctrl1_reg[`CPT_MODE_LO];
  wire         output_function_hi    = ctrl1_reg[`CPT_FUNC_HI];
  wire         output_function_lo    = ctrl1_reg[`CPT_FUNC_LO];
  wire         output_initial_level  = ctrl1_reg[`CPT_INIT_BIT];
  wire         output_invert         = ctrl1_reg[`CPT_INV_BIT];
  wire         duty_period_swap      = ctrl1_reg[`CPT_SWAP_BIT];
  wire         clear_source_select   = ctrl1_reg[`CPT_CLRSEL_BIT];
  wire [1:0]   out_func              = {output_function_hi, output_function_lo};
  wire [1:0]   mode_bits             = {op_mode_hi, op_mode_lo};

  // Mode flags
  wire         mode_cmp  = (mode_bits == CPT_MODE_CMP);
  wire         mode_tmr  = (mode_bits == CPT_MODE_TMR);
  wire         mode_pwm  = (mode_bits == CPT_MODE_PWM);
  wire         mode_cap  = (mode_bits == CPT_MODE_CAP);
  // Timer/counter mode shares all counting and flag behaviour of compare mode
  wire         mode_cmp_like = mode_cmp | mode_tmr;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Fast clock, slow clock and external pin all come from other domains
  wire  [2:0]  pin_raw = {external_timer_clock_pin, slow_clk_in, fast_clk_in};
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync_last_reg;

  // Two flops per pin, then one more to find edges on clean levels only
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi]     <= 1'b0;
          sync2_reg[gi]     <= 1'b0;
          sync_last_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi]     <= pin_raw[gi];
          sync2_reg[gi]     <= sync1_reg[gi];
          sync_last_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // Edge detection on the synchronised levels
  wire         fast_rise = sync2_reg[0] & ~sync_last_reg[0];
  wire         slow_rise = sync2_reg[1] & ~sync_last_reg[1];
  wire         ext_rise  = sync2_reg[2] & ~sync_last_reg[2];
  wire         ext_fall  = ~sync2_reg[2] & sync_last_reg[2];

  // ==========================================================================
  // Clock prescalers
  // ==========================================================================
  logic [1:0]  sys_div_reg;
  logic [5:0]  fast_div_reg;

  // Free-running dividers; they never stop so phase is unrelated to counter start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div_reg  <= 2'h0;
      fast_div_reg <= 6'h00;
    end else begin
      sys_div_reg  <= sys_div_reg + 2'h1;
      if (fast_rise) begin
        fast_div_reg <= fast_div_reg + 6'h01;
      end
    end
  end

  // Prescaled events, one pclk cycle wide each
  wire         sys4_tick  = (sys_div_reg == `CPT_SYS_DIV_LAST);
  wire         fast16_tick = fast_rise & (fast_div_reg[3:0] == `CPT_FAST16_LAST);
  wire         fast64_tick = fast_rise & (fast_div_reg == `CPT_FAST64_LAST);

  // Clock source selection; the fast and slow clocks must run below pclk/2
  wire         src_tick =
      (clock_source_select == CPT_CK_SYS4) ? sys4_tick   :
      (clock_source_select == CPT_CK_SYS)  ? 1'b1        :
      (clock_source_select == CPT_CK_FH16) ? fast16_tick :
      (clock_source_select == CPT_CK_FH64) ? fast64_tick :
      (clock_source_select == CPT_CK_SUBA) ? slow_rise   :
      (clock_source_select == CPT_CK_SUBB) ? slow_rise   :
      (clock_source_select == CPT_CK_EXTR) ? ext_rise    :
                                             ext_fall;

  // ==========================================================================
  // Counter and comparators
  // ==========================================================================
  // Rising edge of the counter-on bit restarts counter and output
  wire         on_rise  = counter_on & ~on_last_reg;
  // Counting only while on and not paused
  // The restart cycle takes no tick, so the stale count can raise no match flag
  wire         tick_run = counter_on & ~counter_pause & src_tick & ~on_rise;
  wire [15:0]  cnt_inc  = cnt_reg + 16'h0001;

  // A matches when the next count reaches value A; zero never matches
  wire         a_hit = tick_run & (compare_a_value_reg != 16'h0000)
                       & (cnt_inc == compare_a_value_reg);
  // P sees the top byte only; zero matches at the wrap from FFFF
  wire         p_hit = tick_run & (cnt_inc == {compare_p_value_reg, 8'h00});

  // Clear source: the select bit counts only in compare-like modes
  wire         clear_on_a = (mode_cmp_like & clear_source_select)
                            | (mode_pwm & duty_period_swap);
  wire         clear_on_p = (mode_cmp_like & ~clear_source_select)
                            | (mode_pwm & ~duty_period_swap)
                            | mode_cap;
  wire         cnt_clear  = (clear_on_a & a_hit) | (clear_on_p & p_hit);

  // Next counter value; turning off simply stops ticks and keeps the value
  always_comb begin
    if (on_rise) begin
      cnt_next = `CPT_RST_CNT;
    end else if (cnt_clear) begin
      cnt_next = `CPT_RST_CNT;
    end else if (tick_run) begin
      cnt_next = cnt_inc;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg     <= `CPT_RST_CNT;
      on_last_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      on_last_reg <= counter_on;
    end
  end

  // Flag events; capture mode raises no A compare flag
  wire         a_set = a_hit & ~mode_cap;
  wire         p_set = p_hit & ~(mode_cmp_like & clear_source_select);

  // ==========================================================================
  // Output pin
  // ==========================================================================
  // Compare mode level: load on start, then act only on A matches
  always_comb begin
    cmp_out_next = cmp_out_reg;
    if (on_rise) begin
      cmp_out_next = output_initial_level;
    end else if (mode_cmp & a_set) begin
      case (out_func)
        2'h0:    cmp_out_next = cmp_out_reg;
        2'h1:    cmp_out_next = 1'b0;
        2'h2:    cmp_out_next = 1'b1;
        2'h3:    cmp_out_next = ~cmp_out_reg;
        default: cmp_out_next = cmp_out_reg;
      endcase
    end
  end

  // Duty value, seventeen bits so P zero can mean a full 65536 count
  wire [16:0]  p_span = (compare_p_value_reg == 8'h00) ? 17'h10000
                        : {1'b0, compare_p_value_reg, 8'h00};
  wire [16:0]  duty   = duty_period_swap ? p_span
                        : {1'b0, compare_a_value_reg};
  // Duty at or above the period is never reached, so the output stays active
  wire         pwm_active = ({1'b0, cnt_reg} < duty);

  // Forced or waveform activity; single pulse is not built and reads inactive
  wire         pwm_act_sel = (out_func == 2'h0) ? 1'b0 :
                             (out_func == 2'h1) ? 1'b1 :
                             (out_func == 2'h2) ? pwm_active : 1'b0;
  // Active level is the initial-level bit, inactive is its complement
  wire         pwm_level   = pwm_act_sel ? output_initial_level
                             : ~output_initial_level;

  // Final pin level; invert applies to both output modes
  wire         pin_level = mode_pwm ? (pwm_level ^ output_invert)
                         : mode_cmp ? (cmp_out_reg ^ output_invert)
                         : 1'b0;
  // Timer/counter and capture modes leave the pin free
  wire         pin_en    = mode_pwm | mode_cmp;

  // Output registers, so the pin is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out_reg <= 1'b0;
      pin_reg     <= 1'b0;
      pin_en_reg  <= 1'b0;
    end else begin
      cmp_out_reg <= cmp_out_next;
      pin_reg     <= pin_level;
      pin_en_reg  <= pin_en;
    end
  end

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire [7:0]   addr8     = paddr[7:0];
  wire         sel_ctrl0 = (addr8 == `CPT_CTRL0_OFS);
  wire         sel_ctrl1 = (addr8 == `CPT_CTRL1_OFS);
  wire         sel_cntlo = (addr8 == `CPT_CNT_LO_OFS);
  wire         sel_cnthi = (addr8 == `CPT_CNT_HI_OFS);
  wire         sel_cmpal = (addr8 == `CPT_CMPA_LO_OFS);
  wire         sel_cmpah = (addr8 == `CPT_CMPA_HI_OFS);
  wire         sel_cmpp  = (addr8 == `CPT_CMPP_OFS);
  wire         sel_flag  = (addr8 == `CPT_FLAG_OFS);
  wire         hi_zero   = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
  wire         mapped    = hi_zero & (sel_ctrl0 | sel_ctrl1 | sel_cntlo | sel_cnthi
                           | sel_cmpal | sel_cmpah | sel_cmpp | sel_flag);

  // Write happens once, in the access phase; unmapped writes are dropped
  wire         wr_acc  = psel & penable & pwrite & mapped;
  wire         rd_set  = psel & ~penable & ~pwrite;
  wire [7:0]   wbyte   = pwdata[7:0];

  // Read multiplexer; reserved and upper bits read as zero
  wire [7:0]   rd_byte =
      ~hi_zero  ? 8'h00 :
      sel_ctrl0 ? (ctrl0_reg & `CPT_CTRL0_MASK) :
      sel_ctrl1 ? ctrl1_reg :
      sel_cntlo ? cnt_reg[7:0] :
      sel_cnthi ? cnt_reg[15:8] :
      sel_cmpal ? compare_a_value_reg[7:0] :
      sel_cmpah ? compare_a_value_reg[15:8] :
      sel_cmpp  ? compare_p_value_reg :
      sel_flag  ? {6'h00, flag_p_reg, flag_a_reg} : 8'h00;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Control and compare registers; counter bytes ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg           <= `CPT_RST_BYTE;
      ctrl1_reg           <= `CPT_RST_BYTE;
      compare_a_value_reg <= {`CPT_RST_BYTE, `CPT_RST_BYTE};
      compare_p_value_reg <= `CPT_RST_BYTE;
    end else if (wr_acc) begin
      if (sel_ctrl0) begin
        ctrl0_reg <= wbyte & `CPT_CTRL0_MASK;
      end
      if (sel_ctrl1) begin
        ctrl1_reg <= wbyte;
      end
      if (sel_cmpal) begin
        compare_a_value_reg[7:0] <= wbyte;
      end
      if (sel_cmpah) begin
        compare_a_value_reg[15:8] <= wbyte;
      end
      if (sel_cmpp) begin
        compare_p_value_reg <= wbyte;
      end
    end
  end

  // Flags clear by writing one; a match in the same cycle wins over the clear
  wire         clr_a = wr_acc & sel_flag & wbyte[`CPT_FLAG_A_BIT];
  wire         clr_p = wr_acc & sel_flag & wbyte[`CPT_FLAG_P_BIT];

  // Sticky match flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      flag_a_reg <= a_set | (flag_a_reg & ~clr_a);
      flag_p_reg <= p_set | (flag_p_reg & ~clr_p);
    end
  end

  // Read data captured in the setup phase, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_set) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Zero wait states: every access completes in its first access cycle
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & ~mapped;
  assign prdata         = prdata_reg;
  assign compare_a_flag = flag_a_reg;
  assign compare_p_flag = flag_p_reg;
  assign timer_out      = pin_reg;
  assign timer_out_en   = pin_en_reg;

endmodule

// ---- cpt_map.svh ----
// Register offsets, field positions, reset values and divider counts of the compare/PWM timer
// ==========================================================================
`ifndef CPT_MAP_SVH
`define CPT_MAP_SVH
// Byte addresses on the APB port
`define CPT_CTRL0_OFS   8'h00
`define CPT_CTRL1_OFS   8'h04
`define CPT_CNT_LO_OFS  8'h08
`define CPT_CNT_HI_OFS  8'h0c
`define CPT_CMPA_LO_OFS 8'h10
`define CPT_CMPA_HI_OFS 8'h14
`define CPT_CMPP_OFS    8'h18
`define CPT_FLAG_OFS    8'h1c
// Control 0 fields
`define CPT_PAUSE_BIT   7
`define CPT_CLKSRC_HI   6
`define CPT_CLKSRC_LO   4
`define CPT_ON_BIT      3
`define CPT_CTRL0_MASK  8'hf8
// Control 1 fields
`define CPT_MODE_HI     7
`define CPT_MODE_LO     6
`define CPT_FUNC_HI     5
`define CPT_FUNC_LO     4
`define CPT_INIT_BIT    3
`define CPT_INV_BIT     2
`define CPT_SWAP_BIT    1
`define CPT_CLRSEL_BIT  0
// Flag fields
`define CPT_FLAG_A_BIT  0
`define CPT_FLAG_P_BIT  1
// Reset values
`define CPT_RST_BYTE    8'h00
`define CPT_RST_CNT     16'h0000
// Divider terminal counts
`define CPT_SYS_DIV_LAST  2'h3
`define CPT_FAST16_LAST   4'hf
`define CPT_FAST64_LAST   6'h3f
`endif

// ---- cpt_pkg.sv ----
// Types shared by the compare/PWM timer
package cpt_pkg;
  // Operating modes, Gray order along the usual path
  typedef enum logic [1:0] {
    CPT_MODE_CMP = 2'h0,
    CPT_MODE_CAP = 2'h1,
    CPT_MODE_TMR = 2'h3,
    CPT_MODE_PWM = 2'h2
  } cpt_mode_e;
  // Counter clock sources
  typedef enum logic [2:0] {
    CPT_CK_SYS4  = 3'h0,
    CPT_CK_SYS   = 3'h1,
    CPT_CK_FH16  = 3'h2,
    CPT_CK_FH64  = 3'h3,
    CPT_CK_SUBA  = 3'h4,
    CPT_CK_SUBB  = 3'h5,
    CPT_CK_EXTR  = 3'h6,
    CPT_CK_EXTF  = 3'h7
  } cpt_clksrc_e;
endpackage

// ---- cpt_timer_properties.sv ----
// Port-level assertions for the compare/PWM timer APB slave and flags
module cpt_timer_properties
  import cpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              compare_a_flag,
  input wire logic              compare_p_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // Decode helpers; misaligned or beyond the flag word is unmapped
  wire acc_w = psel && penable;
  wire unmapped_w = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
  wire flag_clr_w = acc_w && pwrite && (paddr == 8'h1c);
  ready_tied_a: assert property (pready)
    else $error("pready low");
  err_access_a: assert property (pslverr |-> acc_w)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (acc_w && unmapped_w |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (acc_w && !unmapped_w |-> !pslverr)
    else $error("error on mapped address");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_flag_sticky_a: assert property ($fell(compare_a_flag) |-> $past(flag_clr_w && pwdata[0]))
    else $error("A flag cleared without a write");
  p_flag_sticky_a: assert property ($fell(compare_p_flag) |-> $past(flag_clr_w && pwdata[1]))
    else $error("P flag cleared without a write");
endmodule

// ---- cpt_timer_tb_top.sv ----
// Self-checking testbench for the compare/PWM timer
module cpt_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [31:0] v;} cpt_note_s;
  typedef struct {logic [7:0] c1; logic [15:0] a; logic [7:0] p; int wt; int hi;
                  logic [1:0] fl;} cpt_row_s;
  logic        pclk, presetn, psel, penable, pwrite, win;
  logic        win_d = 1'b0, fast_clk_in = 1'b0, slow_clk_in = 1'b0, ext_pin = 1'b0;
  logic        pready, pslverr, flag_a, flag_p;
  logic        tout, tout_en;
  logic [7:0]  paddr, r8;
  logic [31:0] pwdata, prdata;
  int          miscompares, cmp_count;
  int          high_cnt = 0, tk = 0;
  int          seed = 32'h50af;
  cpt_note_s   notes[$];
  // {ctrl1, value A, value P, settle, expected high count, expected flags {P,A}}
  cpt_row_s    rows [16] = '{
    '{8'h31, 16'h0020, 8'h00, 4, 256, 2'h1}, '{8'h21, 16'h0020, 8'h00, 50, 512, 2'h1},
    '{8'h21, 16'h0400, 8'h00, 4, 0, 2'h0}, '{8'h08, 16'h0020, 8'h01, 4, 512, 2'h3},
    '{8'h1c, 16'h0020, 8'h01, 50, 512, 2'h3}, '{8'hc0, 16'h0000, 8'h01, 4, 0, 2'h2},
    '{8'ha8, 16'h0040, 8'h01, 4, 128, 2'h3}, '{8'hac, 16'h0040, 8'h01, 4, 384, 2'h3},
    '{8'ha0, 16'h0040, 8'h01, 4, 384, 2'h3}, '{8'haa, 16'h0080, 8'h01, 4, 512, 2'h1},
    '{8'ha9, 16'h0040, 8'h01, 4, 128, 2'h3}, '{8'h88, 16'h0040, 8'h01, 4, 0, 2'h3},
    '{8'h98, 16'h0040, 8'h01, 4, 512, 2'h3}, '{8'ha8, 16'h0100, 8'h02, 4, 256, 2'h3},
    '{8'hb8, 16'h0040, 8'h01, 4, 0, 2'h3}, '{8'h40, 16'h0020, 8'h01, 4, 0, 2'h2}};
  int          src_hi [8] = '{2, 11, 0, 0, 1, 1, 1, 1};
  cpt_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_clk_in(fast_clk_in), .slow_clk_in(slow_clk_in),
    .external_timer_clock_pin(ext_pin), .compare_a_flag(flag_a),
    .compare_p_flag(flag_p), .timer_out(tout), .timer_out_en(tout_en));
  // =====
  // Clocks; side clocks stay well below half of pclk so no edge is lost
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tk <= tk + 1;
    if (tk % 2 == 0) fast_clk_in <= ~fast_clk_in;
    if (tk % 4 == 0) slow_clk_in <= ~slow_clk_in;
    if (tk % 5 == 0) ext_pin <= ~ext_pin;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pop_chk(input logic [31:0] g);
    cpt_note_s n;
    if (notes.size() == 0) begin
      miscompares++;
      $display("[FAIL] note queue expected entry seen none");
    end else begin
      n = notes.pop_front();
      chk(n.nm, n.v, g);
    end
  endtask
  // Monitor: read data at the completing edge, high counts at window end
  always @(posedge pclk) begin
    win_d <= win;
    high_cnt <= win ? high_cnt + int'(tout === 1'b1) : 0;
    if (psel && penable && pready === 1'b1 && !pwrite) pop_chk(prdata);
    if (win_d && !win) begin
      pop_chk(high_cnt);
      pop_chk({31'h0, tout_en});
    end
  end
  // =====
  // Bus and observation tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    notes.push_back('{"prdata", {24'h0, e}});
    apb(1'b0, a, 8'h00);
  endtask
  task automatic win_cnt(input int e, input logic en);
    notes.push_back('{"high_count", e});
    notes.push_back('{"out_enable", {31'h0, en}});
    win <= 1'b1;
    repeat (512) @(posedge pclk);
    win <= 1'b0;
  endtask
  task automatic end_of_test();
    // A note never answered is a missing result
    if (notes.size() != 0) miscompares++;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the roughly 34000 cycles of the sequence
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, win} = '0;
    {paddr, pwdata, miscompares, cmp_count} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h02, 8'h00);
    apb(1'b1, 8'h08, 8'h5a);
    rd(8'h08, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r8 = 8'($random(seed));
      apb(1'b1, 8'h04 + 8'(i) * 8'h04 + (i > 0 ? 8'h08 : 8'h00), r8);
      rd(8'h04 + 8'(i) * 8'h04 + (i > 0 ? 8'h08 : 8'h00), r8);
    end
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, 8'h10);
      apb(1'b1, 8'h04, rows[i].c1);
      apb(1'b1, 8'h10, rows[i].a[7:0]);
      apb(1'b1, 8'h14, rows[i].a[15:8]);
      apb(1'b1, 8'h18, rows[i].p);
      apb(1'b1, 8'h1c, 8'h03);
      apb(1'b1, 8'h00, 8'h18);
      repeat (rows[i].wt) @(posedge pclk);
      if (rows[i].hi >= 0) win_cnt(rows[i].hi, !rows[i].c1[6]);
      rd(8'h1c, {6'h0, rows[i].fl});
    end
    // Pause holds, off keeps, on restarts from zero
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h18, 8'h00);
    apb(1'b1, 8'h00, 8'h10);
    apb(1'b1, 8'h00, 8'h18);
    repeat (300) @(posedge pclk);
    apb(1'b1, 8'h00, 8'h98);
    repeat (300) @(posedge pclk);
    rd(8'h0c, 8'h01);
    apb(1'b1, 8'h00, 8'h18);
    repeat (300) @(posedge pclk);
    rd(8'h0c, 8'h02);
    apb(1'b1, 8'h00, 8'h10);
    repeat (300) @(posedge pclk);
    rd(8'h0c, 8'h02);
    apb(1'b1, 8'h00, 8'h18);
    rd(8'h0c, 8'h00);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 8'h00, {1'b0, 3'(s), 4'h0});
      apb(1'b1, 8'h00, {1'b0, 3'(s), 4'h8});
      repeat (3000) @(posedge pclk);
      rd(8'h0c, 8'(src_hi[s]));
    end
    repeat (4) @(posedge pclk);
    end_of_test();
  end
endmodule
bind cpt_timer cpt_timer_properties #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));
